// file: hdl/ple_engine.sv
`timescale 1ns/1ps
module ple_engine
  import ple_pkg::*;
#(
  parameter int NUM_EQ = 16, // Equation slots
  parameter int NUM_EXT = 32, // External signals
  parameter int DLY_W = 16, // Width of delay settings
  parameter int ADDR_W = 9 // Register address width
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [NUM_EXT-1:0] sig_in, // Protection signals, same clock
  input wire logic [ADDR_W-1:0] reg_addr, // Register word address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic [NUM_EQ-1:0] eq_out, // Unlatched outputs
  output logic [NUM_EQ-1:0] eq_latched, // Latched outputs
  output logic [NUM_EQ-1:0] eq_latched_n, // Inverted latched outputs
  output logic [$clog2(NUM_EQ)-1:0] eval_index, // Slot under evaluation
  output logic pass_done // Last slot evaluated
);
  localparam int IDX_W = $clog2(NUM_EQ);
  localparam int AE_W = ADDR_W - 3;
  localparam int NUM_SIG = NUM_EXT + 3 * NUM_EQ;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_EQ - 1);

  logic [IDX_W-1:0] idx_reg;
  logic [15:0] pass_cnt_reg;
  logic [NUM_EXT-1:0] ext_snap_reg;
  logic [31:0] cfg_sel_mem [NUM_EQ];
  logic [31:0] cfg_ctl_mem [NUM_EQ];
  logic [31:0] cfg_dly_mem [NUM_EQ];
  logic [DLY_W-1:0] cnt_mem [NUM_EQ];
  logic [EQ_IN_N-1:0] cond_mem [NUM_EQ];
  logic [NUM_EQ-1:0] gate_reg;
  logic [NUM_SIG-1:0] sig_vec;
  logic [31:0] cur_sel;
  logic [31:0] cur_ctl;
  logic [31:0] cur_dly;
  logic [EQ_IN_N-1:0] raw_in;
  logic [EQ_IN_N-1:0] cond_in;
  logic [EQ_IN_N-1:0] inv_bits;
  logic gate_res;
  ple_gate_t gate_fn;
  logic rst_raw;
  logic rst_eff;
  logic [DLY_W-1:0] on_dly;
  logic [DLY_W-1:0] off_dly;
  logic cur_out;
  logic cur_lat;
  logic [DLY_W-1:0] cur_cnt;
  logic out_nxt;
  logic lat_nxt;
  logic [DLY_W-1:0] cnt_nxt;
  logic [AE_W-1:0] a_eq;
  logic eq_hit;
  logic [IDX_W-1:0] a_idx;
  logic [31:0] rd_word;

  // Level of signal number s, zero beyond the list
  function automatic logic pick(input logic [SEL_W-1:0] s,
                                input logic [NUM_SIG-1:0] v);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_SIG; i++) begin
      if (s == SEL_W'(i)) begin
        hit = v[i];
      end
    end
    return hit;
  endfunction

  // Signal list: snapped external signals, then three outputs per slot
  assign sig_vec[NUM_EXT-1:0] = ext_snap_reg;
  for (genvar j = 0; j < NUM_EQ; j++) begin : g_fb
    // Slots below the index are already updated this pass, the rest not
    assign sig_vec[NUM_EXT + 3 * j] = eq_out[j];
    assign sig_vec[NUM_EXT + 3 * j + 1] = eq_latched[j];
    assign sig_vec[NUM_EXT + 3 * j + 2] = eq_latched_n[j];
  end

  // Configuration of the slot under evaluation
  assign cur_sel = cfg_sel_mem[idx_reg];
  assign cur_ctl = cfg_ctl_mem[idx_reg];
  assign cur_dly = cfg_dly_mem[idx_reg];
  assign inv_bits = cur_ctl[CTL_INV_LSB +: EQ_IN_N];
  assign gate_fn = ple_gate_t'(cur_ctl[CTL_GATE_LSB +: 2]);
  assign on_dly = cur_dly[DLY_ON_LSB +: DLY_W];
  assign off_dly = cur_dly[DLY_OFF_LSB +: DLY_W];
  assign cur_out = eq_out[idx_reg];
  assign cur_lat = eq_latched[idx_reg];
  assign cur_cnt = cnt_mem[idx_reg];

  // Input selection per gate input
  for (genvar k = 0; k < EQ_IN_N; k++) begin : g_sel
    assign raw_in[k] = pick(cur_sel[SEL_W * k +: SEL_W], sig_vec);
  end

  // Latch reset input with optional negation
  assign rst_raw = pick(cur_ctl[CTL_RSEL_LSB +: SEL_W], sig_vec);
  assign rst_eff = rst_raw ^ cur_ctl[CTL_RINV_BIT];

  // Conditioning and gate
  ple_gate #(
    .IN_N(EQ_IN_N)
  ) u_gate (
    .raw(raw_in),
    .inv(inv_bits),
    .fn(gate_fn),
    .cond(cond_in),
    .result(gate_res)
  );

  // Delays and latch
  ple_timer_latch #(
    .DLY_W(DLY_W)
  ) u_timer (
    .gate(gate_res),
    .out_cur(cur_out),
    .cnt_cur(cur_cnt),
    .on_dly(on_dly),
    .off_dly(off_dly),
    .lat_cur(cur_lat),
    .lat_rst(rst_eff),
    .out_nxt(out_nxt),
    .cnt_nxt(cnt_nxt),
    .lat_nxt(lat_nxt)
  );

  // Slot sequencer, one slot per enabled cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_reg <= '0;
      pass_cnt_reg <= PASS_RST;
      pass_done <= 1'b0;
    end else if (ce) begin
      pass_done <= (idx_reg == LAST_IDX);
      if (idx_reg == LAST_IDX) begin
        idx_reg <= '0;
        pass_cnt_reg <= pass_cnt_reg + 1'b1;
      end else begin
        idx_reg <= idx_reg + 1'b1;
      end
    end
  end

  // External signals held steady for a whole pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_snap_reg <= '0;
    end else if (ce && idx_reg == LAST_IDX) begin
      ext_snap_reg <= sig_in;
    end
  end

  // Outputs of the slot under evaluation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_out <= '0;
      eq_latched <= '0;
      eq_latched_n <= '1;
      gate_reg <= '0;
    end else if (ce) begin
      eq_out[idx_reg] <= out_nxt;
      eq_latched[idx_reg] <= lat_nxt;
      eq_latched_n[idx_reg] <= ~lat_nxt;
      gate_reg[idx_reg] <= gate_res;
    end
  end

  // Per-slot delay counts and input status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EQ; i++) begin
        cnt_mem[i] <= '0;
        cond_mem[i] <= '0;
      end
    end else if (ce) begin
      cnt_mem[idx_reg] <= cnt_nxt;
      cond_mem[idx_reg] <= cond_in;
    end
  end

  // Register address decode
  assign a_eq = reg_addr[ADDR_W-2:2];
  // Compared as int so a full slot range cannot wrap the limit to zero
  assign eq_hit = !reg_addr[ADDR_W-1] && (int'(a_eq) < NUM_EQ);
  assign a_idx = IDX_W'(a_eq);

  // Configuration writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EQ; i++) begin
        cfg_sel_mem[i] <= CFG_RST;
        cfg_ctl_mem[i] <= CFG_RST;
        cfg_dly_mem[i] <= CFG_RST;
      end
    end else if (ce && reg_wr && eq_hit) begin
      unique case (reg_addr[1:0])
        WORD_SEL: cfg_sel_mem[a_idx] <= reg_wdata;
        WORD_CTL: cfg_ctl_mem[a_idx] <= reg_wdata & CTL_MASK;
        WORD_DLY: cfg_dly_mem[a_idx] <= reg_wdata;
        WORD_STAT: cfg_sel_mem[a_idx] <= cfg_sel_mem[a_idx];
      endcase
    end
  end

  // Read word selection
  always_comb begin
    rd_word = '0;
    if (reg_addr == ADDR_W'(GSTAT_ADDR)) begin
      rd_word[GS_PASS_LSB +: 16] = pass_cnt_reg;
      rd_word[GS_IDX_LSB +: IDX_W] = idx_reg;
    end else if (eq_hit) begin
      unique case (reg_addr[1:0])
        WORD_SEL: rd_word = cfg_sel_mem[a_idx];
        WORD_CTL: rd_word = cfg_ctl_mem[a_idx];
        WORD_DLY: rd_word = cfg_dly_mem[a_idx];
        WORD_STAT: begin
          rd_word[ST_COND_LSB +: EQ_IN_N] = cond_mem[a_idx];
          rd_word[ST_GATE_BIT] = gate_reg[a_idx];
          rd_word[ST_OUT_BIT] = eq_out[a_idx];
          rd_word[ST_LAT_BIT] = eq_latched[a_idx];
          rd_word[ST_LATN_BIT] = eq_latched_n[a_idx];
          rd_word[ST_CNT_LSB +: DLY_W] = cnt_mem[a_idx];
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_word : '0;
    end
  end

  assign eval_index = idx_reg;

  // Checks on the evaluation logic and register reads
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_idx_order: assert property (
    ce && idx_reg != LAST_IDX |=> idx_reg == $past(idx_reg) + 1'b1)
  else $error("slot index did not step up by one");

  chk_pass_wrap: assert property (
    ce && idx_reg == LAST_IDX
      |=> idx_reg == '0 && pass_done && pass_cnt_reg == $past(pass_cnt_reg) + 1'b1)
  else $error("pass did not wrap to slot zero");

  chk_input_negate: assert property (
    ce |-> cond_in == (raw_in ^ inv_bits))
  else $error("conditioned inputs differ from selection and negate bits");

  chk_reset_prio: assert property (
    ce && rst_eff && out_nxt
      |=> !eq_latched[$past(idx_reg)] && eq_latched_n[$past(idx_reg)])
  else $error("latch set while its reset was active");

  chk_latch_hold: assert property (
    ce && (cur_lat || out_nxt) && !rst_eff |=> eq_latched[$past(idx_reg)])
  else $error("latch lost without reset");

  chk_latch_comp: assert property (
    eq_latched_n == ~eq_latched)
  else $error("inverted latch output not the complement");

  chk_zero_delay: assert property (
    ce && on_dly == '0 && off_dly == '0
      |=> eq_out[$past(idx_reg)] == $past(gate_res))
  else $error("zero delay did not pass the gate through");

  chk_delay_hold: assert property (
    ce && gate_res != cur_out && cur_cnt < (gate_res ? on_dly : off_dly)
      |=> eq_out[$past(idx_reg)] == $past(cur_out)
        && cnt_mem[$past(idx_reg)] == $past(cur_cnt) + 1'b1)
  else $error("output changed before its delay ran out");

  chk_status_read: assert property (
    ce && reg_rd && reg_addr == ADDR_W'(GSTAT_ADDR)
      |=> reg_rdata[GS_PASS_LSB +: 16] == $past(pass_cnt_reg))
  else $error("global status read returned a wrong pass count");

  chk_read_idle: assert property (
    ce && !reg_rd |=> reg_rdata == '0)
  else $error("read data present without a read strobe");
endmodule

// file: shared/ple_pkg.sv
package ple_pkg;
  // Width of one signal selector inside the selector word
  localparam int SEL_W = 8;
  // Inputs per equation
  localparam int EQ_IN_N = 4;

  // Word offsets within one equation's group of four registers
  localparam logic [1:0] WORD_SEL = 2'h0;
  localparam logic [1:0] WORD_CTL = 2'h1;
  localparam logic [1:0] WORD_DLY = 2'h2;
  localparam logic [1:0] WORD_STAT = 2'h3;
  // Global status word address
  localparam logic [8:0] GSTAT_ADDR = 9'h100;

  // Control word fields
  localparam int CTL_RSEL_LSB = 0;
  localparam int CTL_INV_LSB = 8;
  localparam int CTL_RINV_BIT = 12;
  localparam int CTL_GATE_LSB = 13;
  localparam logic [31:0] CTL_MASK = 32'h0000_7fff;
  // Delay word fields
  localparam int DLY_ON_LSB = 0;
  localparam int DLY_OFF_LSB = 16;
  // Equation status word fields
  localparam int ST_COND_LSB = 0;
  localparam int ST_GATE_BIT = 4;
  localparam int ST_OUT_BIT = 5;
  localparam int ST_LAT_BIT = 6;
  localparam int ST_LATN_BIT = 7;
  localparam int ST_CNT_LSB = 16;
  // Global status fields
  localparam int GS_PASS_LSB = 0;
  localparam int GS_IDX_LSB = 16;

  // Values after reset
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] PASS_RST = 16'h0000;

  // Gate functions
  typedef enum logic [1:0] {GATE_AND, GATE_OR, GATE_NAND, GATE_NOR} ple_gate_t;
endpackage

// file: hdl/ple_gate.sv
`timescale 1ns/1ps
module ple_gate
  import ple_pkg::*;
#(
  parameter int IN_N = 4 // Inputs of the gate
) (
  input wire logic [IN_N-1:0] raw, // Selected input levels
  input wire logic [IN_N-1:0] inv, // Per-input negate bits
  input wire ple_gate_t fn, // Gate function
  output logic [IN_N-1:0] cond, // Conditioned inputs
  output logic result // Gate result
);
  // Optional negation of each input
  for (genvar k = 0; k < IN_N; k++) begin : g_inv
    assign cond[k] = raw[k] ^ inv[k];
  end

  // Gate across the conditioned inputs
  always_comb begin
    result = 1'b0;
    unique case (fn)
      GATE_AND: result = &cond;
      GATE_OR: result = |cond;
      GATE_NAND: result = ~&cond;
      GATE_NOR: result = ~|cond;
    endcase
  end
endmodule

// file: hdl/ple_timer_latch.sv
`timescale 1ns/1ps
module ple_timer_latch
  import ple_pkg::*;
#(
  parameter int DLY_W = 16 // Width of delay counts
) (
  input wire logic gate, // Gate result this pass
  input wire logic out_cur, // Delayed output, last pass
  input wire logic [DLY_W-1:0] cnt_cur, // Passes counted so far
  input wire logic [DLY_W-1:0] on_dly, // Turn-on delay in passes
  input wire logic [DLY_W-1:0] off_dly, // Turn-off delay in passes
  input wire logic lat_cur, // Latch, last pass
  input wire logic lat_rst, // Conditioned latch reset
  output logic out_nxt, // New delayed output
  output logic [DLY_W-1:0] cnt_nxt, // New pass count
  output logic lat_nxt // New latch state
);
  logic [DLY_W-1:0] dly_sel;

  // Delay that applies to the pending edge
  assign dly_sel = gate ? on_dly : off_dly;

  // Output follows the gate after the chosen number of passes
  always_comb begin
    out_nxt = out_cur;
    cnt_nxt = '0;
    if (gate != out_cur) begin
      if (cnt_cur >= dly_sel) begin
        out_nxt = gate;
      end else begin
        cnt_nxt = cnt_cur + 1'b1;
      end
    end
  end

  // Reset-dominant latch set by the delayed result
  always_comb begin
    if (lat_rst) begin
      lat_nxt = 1'b0;
    end else if (out_nxt) begin
      lat_nxt = 1'b1;
    end else begin
      lat_nxt = lat_cur;
    end
  end
endmodule

// file: bench/ple_sig_model.sv
`timescale 1ns/1ps
// Protection signal source; levels move only just after a clock edge
module ple_sig_model #(
  parameter int N = 8 // Signal count
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic [N-1:0] want, // Levels requested by the bench
  output logic [N-1:0] sig_in // Levels toward the engine
);
  // Register requested levels, same clock as the engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sig_in <= '0;
    else sig_in <= want;
  end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ple_pkg::*;
  logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [8:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [31:0] reg_rdata;
  logic [7:0] want = '0;
  logic [7:0] sig_in;
  logic [3:0] eq_out, eq_latched, eq_latched_n, inv, c;
  logic [1:0] eval_index, fn;
  logic pass_done, g;
  int fails = 0, checked = 0, cyc = 0;
  logic [31:0] exp_q[$], msk_q[$];
  logic [3:0] cas [6] = '{4'h3, 4'h3, 4'hb, 4'hb, 4'hb, 4'hf};

  ple_sig_model #(.N(8)) ple_sig_model_i (.clk(clk), .rst(rst), .want(want), .sig_in(sig_in));
  ple_engine #(.NUM_EQ(4), .NUM_EXT(8)) ple_engine_i (
    .clk(clk), .rst(rst), .ce(ce), .sig_in(sig_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eq_out(eq_out), .eq_latched(eq_latched), .eq_latched_n(eq_latched_n),
    .eval_index(eval_index), .pass_done(pass_done)
  );

  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Read results stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (rd_q) chk("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
  end

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
  endtask

  task automatic passes(input int n);
    repeat (4 * n) @(posedge clk);
    @(negedge clk);
  endtask

  // Slot 1 unlatched, latched and inverted latched outputs after new levels
  task automatic lat(input logic [7:0] v, input logic [2:0] e);
    @(posedge clk);
    want <= v;
    passes(3);
    chk("slot1 out lat latn", e, {eq_out[1], eq_latched[1], eq_latched_n[1]});
  endtask

  // Cycles from slot 0 change to delayed slot 1 change
  task automatic lag(input logic v, input int e);
    int n;
    @(posedge clk);
    want[4] <= v;
    for (int k = 0; k < 40 && eq_out[0] !== v; k++) @(negedge clk);
    n = 0;
    while (n < 40 && eq_out[1] !== v) begin
      @(negedge clk);
      n++;
    end
    chk("turn delay", e, n);
  endtask

  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h2a82));
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("latched_n at reset", 32'hf, eq_latched_n);
    @(posedge clk);
    rst <= 0;
    // First edge after release evaluates slot 0; read sampled on the second sees slot 1
    rd(9'h100, 32'h0001_0000, 32'hffff_ffff);
    rd(9'h001, 32'h0, 32'hffff_ffff);
    wr(9'h003, 32'h1234);
    rd(9'h003, 32'h80, 32'hff);
    wr(9'h001, 32'hffff_ffff);
    rd(9'h001, CTL_MASK, 32'hffff_ffff);
    rd(9'h1ff, 32'h0, 32'hffff_ffff);
    // Gate functions and input negation on slot 0
    wr(9'h000, 32'h0302_0100);
    for (int i = 0; i < 8; i++) begin
      fn = i[1:0];
      inv = 4'($urandom);
      wr(9'h001, {17'h0, fn, 1'b0, inv, 8'hff});
      want <= {4'h0, 4'($urandom)};
      @(posedge clk);
      c = want[3:0] ^ inv;
      g = (fn[0] ? |c : &c) ^ fn[1];
      passes(3);
      rd(9'h003, {26'h0, g, g, c}, 32'h3f);
    end
    // Chain 0 -> 1 -> 3 -> 2, slot 1 latch reset on signal 5
    want <= '0;
    wr(9'h000, 32'hffff_ff04);
    wr(9'h001, 32'h0000_20ff);
    wr(9'h004, 32'hffff_ff08);
    wr(9'h005, 32'h0000_2005);
    wr(9'h00c, 32'hffff_ff0b);
    wr(9'h00d, 32'h0000_20ff);
    wr(9'h008, 32'hffff_ff11);
    wr(9'h009, 32'h0000_20ff);
    passes(3);
    @(posedge clk);
    want[4] <= 1;
    for (int k = 0; k < 40 && eq_out[0] !== 1'b1; k++) @(negedge clk);
    chk("eval_index", 32'h1, eval_index);
    foreach (cas[k]) begin
      @(negedge clk);
      chk("cascade", cas[k], eq_out);
    end
    @(negedge clk);
    chk("pass_done", 32'h1, pass_done);
    // Latch set, hold, reset priority, reset negation
    lat(8'h00, 3'b010);
    lat(8'h30, 3'b101);
    wr(9'h005, 32'h0000_3005);
    lat(8'h30, 3'b110);
    lat(8'h10, 3'b101);
    // Delays on slot 1: on 2 passes, off 1 pass
    wr(9'h004, 32'hffff_ff04);
    wr(9'h005, 32'h0000_20ff);
    wr(9'h006, 32'h0001_0002);
    rd(9'h006, 32'h0001_0002, 32'hffff_ffff);
    passes(4);
    lag(1'b0, 5);
    lag(1'b1, 9);
    // Clock enable low freezes evaluation
    @(posedge clk);
    ce <= 0;
    @(negedge clk);
    c = {2'b0, eval_index};
    repeat (5) @(negedge clk);
    chk("frozen index", c, eval_index);
    @(posedge clk);
    ce <= 1;
    passes(1);
    finish_test();
  end
endmodule
